// *** ldm_mode_fault_ctrl.v ***
/*
 * Mode and fault controller of a single-LED flash driver with its
 * register slave on the two-wire serial pins.
 * Assumes all analog indications, the trigger and the serial pins are
 * asynchronous to sys_clk_in; the SDA pin is open-drain with a pull-up.
 */
`timescale 1ns/100ps
`include "ldm_consts.vh"

module ldm_mode_fault_ctrl #(
	parameter        MS_CYCLES = `LDM_MS_US * `LDM_CLK_MHZ,
	parameter [6:0]  DEV_ADDR  = `LDM_I2C_ADDR,
	parameter [7:0]  ID_VALUE  = 8'h5A // Arbitrary identity value.
) (
	// Clock, reset and clock enable.
	input  wire       sys_clk_in,
	input  wire       rst_b_in,
	input  wire       clk_en_in,
	// Serial register pins.
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe_out,
	// Trigger and analog indications.
	input  wire       trigger_in,
	input  wire       supply_droop_monitor_in,
	input  wire       led_short_in,
	input  wire       thermal_scaleback_in,
	input  wire       thermal_shutdown_in,
	input  wire       undervoltage_lockout_in,
	// Drive outputs.
	output wire [7:0] current_code_out,
	output wire [1:0] drive_mode_field_out,
	output wire [2:0] droop_threshold_out,
	output wire       fault_lock_out
);

	localparam [4:0] PH_IDLE  = 5'h01;
	localparam [4:0] PH_ADDR  = 5'h02;
	localparam [4:0] PH_REG   = 5'h04;
	localparam [4:0] PH_WDATA = 5'h08;
	localparam [4:0] PH_RDATA = 5'h10;

	localparam [3:0] ST_SB = 4'h1;
	localparam [3:0] ST_FL = 4'h2;
	localparam [3:0] ST_TO = 4'h4;
	localparam [3:0] ST_IR = 4'h8;

	localparam [11:0] DEGLITCH_CYC = `LDM_SHORT_DEGLITCH_CYC;
	localparam [7:0]  TORCH_STEP   = `LDM_TORCH_STEP_CYC;
	localparam [7:0]  FLASH_STEP   = `LDM_FLASH_STEP_CYC;
	localparam [31:0] MS_LAST      = MS_CYCLES - 1;

	wire [7:0] async_w = {undervoltage_lockout_in, thermal_shutdown_in, thermal_scaleback_in, led_short_in,
		supply_droop_monitor_in, trigger_in, sda_in, scl_in};
	reg  [7:0] sy1_q;
	reg  [7:0] sy2_q;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
			always @(posedge sys_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					sy1_q[gi] <= 1'b0;
					sy2_q[gi] <= 1'b0;
				end else if (clk_en_in) begin
					sy1_q[gi] <= async_w[gi];
					sy2_q[gi] <= sy1_q[gi];
				end
			end
		end
	endgenerate

	wire scl_s   = sy2_q[0];
	wire sda_s   = sy2_q[1];
	wire trig_s  = sy2_q[2];
	wire droop_s = sy2_q[3];
	wire short_s = sy2_q[4];
	wire tsb_s   = sy2_q[5];
	wire tsd_s   = sy2_q[6];
	wire undervoltage_lockout_s  = sy2_q[7];

	reg  [4:0]  ph_q;
	reg  [3:0]  cnt_q;
	reg  [7:0]  sh_q;
	reg  [7:0]  ptr_q;
	reg         rw_q;
	reg         mack_q;
	reg         sda_oe_q;
	reg         scl_p_q;
	reg         sda_p_q;
	reg         droop_p_q;
	reg  [7:0]  en_q;
	reg  [7:0]  cfg_q;
	reg  [7:0]  flash_q;
	reg  [7:0]  torch_q;
	reg  [7:0]  flags_q;
	reg         lock_q;
	reg         tsb_q;
	reg  [3:0]  st_q;
	reg  [3:0]  st_d;
	reg  [7:0]  code_q;
	reg  [7:0]  stp_q;
	reg  [15:0] pre_q;
	reg  [10:0] ms_q;
	reg  [11:0] sc_q;
	reg  [7:0]  rd_mux;
	reg  [7:0]  target;
	reg  [7:0]  en_d;

	function [10:0] timeout_ms;
		input [3:0] c;
		begin
			if (c < `LDM_TIMEOUT_FINE_CODES) begin
				timeout_ms = ({7'h00, c} + 11'h001) * `LDM_TIMEOUT_FINE_MS;
			end else begin
				timeout_ms = `LDM_TIMEOUT_COARSE_MS + ({7'h00, c} - {7'h00, `LDM_TIMEOUT_FINE_CODES})
					* `LDM_TIMEOUT_COARSE_STEP;
			end
		end
	endfunction

	wire scl_rise = scl_s & ~scl_p_q;
	wire scl_fall = ~scl_s & scl_p_q;
	wire start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
	wire stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;
	wire busy     = ~ph_q[0];

	wire load_rd = scl_fall & busy & (cnt_q == 4'h9) & ((ph_q == PH_ADDR & rw_q) | (ph_q == PH_RDATA & mack_q));
	wire wr_en   = scl_fall & (cnt_q == 4'h8) & (ph_q == PH_WDATA);
	wire rd_clr  = load_rd & (ptr_q == `LDM_REG_FLAGS);
	wire swrst   = wr_en & (ptr_q == `LDM_REG_IDENT) & sh_q[`LDM_ID_SOFT_RESET];

	always @* begin
		if (ptr_q == `LDM_REG_ENABLE) begin
			rd_mux = en_q;
		end else if (ptr_q == `LDM_REG_CONFIG) begin
			rd_mux = cfg_q;
		end else if (ptr_q == `LDM_REG_FLASH) begin
			rd_mux = flash_q;
		end else if (ptr_q == `LDM_REG_TORCH) begin
			rd_mux = torch_q;
		end else if (ptr_q == `LDM_REG_FLAGS) begin
			rd_mux = flags_q;
		end else if (ptr_q == `LDM_REG_IDENT) begin
			rd_mux = ID_VALUE;
		end else begin
			rd_mux = 8'h00;
		end
	end

	// Serial slave: bits are sampled on SCL rise and driven after SCL fall.
	always @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ph_q     <= PH_IDLE;
			cnt_q    <= 4'h0;
			sh_q     <= 8'h00;
			ptr_q    <= 8'h00;
			rw_q     <= 1'b0;
			mack_q   <= 1'b0;
			sda_oe_q <= 1'b0;
			scl_p_q  <= 1'b0;
			sda_p_q  <= 1'b0;
		end else if (clk_en_in) begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
			if (start_c) begin
				ph_q     <= PH_ADDR;
				cnt_q    <= 4'h0;
				sda_oe_q <= 1'b0;
			end else if (stop_c) begin
				ph_q     <= PH_IDLE;
				sda_oe_q <= 1'b0;
			end else if (scl_rise & busy) begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q < 4'h8) begin
					sh_q <= {sh_q[6:0], sda_s};
				end
				if (cnt_q == 4'h8) begin
					mack_q <= ~sda_s;
				end
			end else if (scl_fall & busy) begin
				if (cnt_q == 4'h8) begin
					if (ph_q == PH_ADDR) begin
						if (sh_q[7:1] == DEV_ADDR) begin
							sda_oe_q <= 1'b1;
							rw_q     <= sh_q[0];
						end else begin
							ph_q <= PH_IDLE;
						end
					end else if (ph_q == PH_REG) begin
						ptr_q    <= sh_q;
						sda_oe_q <= 1'b1;
					end else if (ph_q == PH_WDATA) begin
						sda_oe_q <= 1'b1;
					end else begin
						sda_oe_q <= 1'b0;
					end
				end else if (cnt_q == 4'h9) begin
					cnt_q <= 4'h0;
					if (load_rd) begin
						ph_q     <= PH_RDATA;
						sh_q     <= rd_mux;
						sda_oe_q <= ~rd_mux[7];
					end else if (ph_q == PH_RDATA) begin
						ph_q     <= PH_IDLE;
						sda_oe_q <= 1'b0;
					end else begin
						sda_oe_q <= 1'b0;
						ph_q     <= (ph_q == PH_ADDR) ? PH_REG : PH_WDATA;
					end
				end else if (ph_q == PH_RDATA) begin
					sda_oe_q <= ~sh_q[7];
				end
			end
		end
	end

	always @* begin
		case (en_q[1:0])
			`LDM_MODE_FLASH:    st_d = ST_FL;
			`LDM_MODE_TORCH:    st_d = ST_TO;
			`LDM_MODE_INFRARED: st_d = ST_IR;
			default:            st_d = ST_SB;
		endcase
	end

	wire ir_on    = st_q[3] & en_q[`LDM_EN_TRIG_ENABLE] & trig_s;
	wire t_run    = st_q[1] | ir_on;
	wire expired  = t_run & (ms_q >= timeout_ms(cfg_q[`LDM_CFG_TIMEOUT_MSB:`LDM_CFG_TIMEOUT_LSB]));
	wire short_ok = (sc_q == DEGLITCH_CYC - 12'h001);
	wire fault    = short_ok | tsd_s | undervoltage_lockout_s;

	// Hardware sets are ORed in after the clears so an event in a read cycle survives.
	wire [7:0] flag_set = {1'b0,
		droop_s & ~droop_p_q & en_q[`LDM_EN_DROOP_ENABLE],
		short_ok, 2'b00,
		(tsb_s & st_q[1]) | tsd_s,
		undervoltage_lockout_s, 1'b0};
	wire [7:0] flag_clr = ({8{rd_clr}}) | ({8{swrst}} & (8'h01 << `LDM_FLG_SHORT));

	always @* begin
		en_d = en_q;
		if (wr_en & (ptr_q == `LDM_REG_ENABLE)) begin
			en_d = sh_q;
		end
		if (fault | lock_q | expired) begin
			en_d[1:0] = `LDM_MODE_STANDBY;
		end
	end

	always @* begin
		if (st_q[1]) begin
			target = tsb_q ? {1'b0, torch_q[6:0]} : {1'b0, flash_q[6:0]};
		end else if (st_q[2]) begin
			target = {1'b0, torch_q[6:0]};
		end else begin
			target = flash_q;
		end
	end

	wire [7:0] step_len = st_q[1] ? FLASH_STEP : TORCH_STEP;
	wire       step_hit = (stp_q == step_len - 8'h01);
	wire       halted   = st_q[1] & droop_s & en_q[`LDM_EN_DROOP_ENABLE];

	always @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			en_q      <= `LDM_RST_ENABLE;
			cfg_q     <= `LDM_RST_CONFIG;
			flash_q   <= `LDM_RST_FLASH;
			torch_q   <= `LDM_RST_TORCH;
			flags_q   <= `LDM_RST_FLAGS;
			lock_q    <= 1'b0;
			tsb_q     <= 1'b0;
			droop_p_q <= 1'b0;
			st_q      <= ST_SB;
			code_q    <= 8'h00;
			stp_q     <= 8'h00;
			pre_q     <= 16'h0000;
			ms_q      <= 11'h000;
			sc_q      <= 12'h000;
		end else if (clk_en_in) begin
			droop_p_q <= droop_s;
			flags_q   <= (flags_q & ~flag_clr) | flag_set;
			lock_q    <= fault | (lock_q & ~rd_clr);
			st_q      <= st_d;
			if (swrst) begin
				en_q    <= `LDM_RST_ENABLE;
				cfg_q   <= `LDM_RST_CONFIG;
				flash_q <= `LDM_RST_FLASH;
				torch_q <= `LDM_RST_TORCH;
			end else begin
				en_q <= en_d;
				if (wr_en & (ptr_q == `LDM_REG_CONFIG)) begin
					cfg_q <= sh_q;
				end
				if (wr_en & (ptr_q == `LDM_REG_FLASH)) begin
					flash_q <= sh_q;
				end
				if (wr_en & (ptr_q == `LDM_REG_TORCH)) begin
					torch_q <= sh_q;
				end
			end
			// Scale-back holds for the rest of this flash and rearms on the next.
			tsb_q <= st_q[1] & (tsb_q | tsb_s);
			if ((st_q[1] | st_q[2]) & short_s) begin
				if (!short_ok) begin
					sc_q <= sc_q + 12'h001;
				end
			end else begin
				sc_q <= 12'h000;
			end
			if (t_run) begin
				if ({16'h0000, pre_q} == MS_LAST) begin
					pre_q <= 16'h0000;
					ms_q  <= ms_q + 11'h001;
				end else begin
					pre_q <= pre_q + 16'h0001;
				end
			end else begin
				pre_q <= 16'h0000;
				ms_q  <= 11'h000;
			end
			if (st_d != st_q) begin
				code_q <= 8'h00;
				stp_q  <= 8'h00;
			end else if (st_q[1] | st_q[2]) begin
				if ((code_q > target) | (st_q[2] & ~cfg_q[`LDM_CFG_TORCH_RAMP])) begin
					code_q <= target;
				end else if ((code_q < target) & ~halted) begin
					if (step_hit) begin
						stp_q  <= 8'h00;
						code_q <= code_q + 8'h01;
					end else begin
						stp_q <= stp_q + 8'h01;
					end
				end
			end else if (st_q[3]) begin
				code_q <= ir_on ? target : 8'h00;
			end else begin
				code_q <= 8'h00;
			end
		end
	end

	assign sda_out              = 1'b0;
	assign sda_oe_out           = sda_oe_q;
	assign current_code_out     = code_q;
	assign drive_mode_field_out = en_q[1:0];
	assign droop_threshold_out  = cfg_q[`LDM_CFG_DROOP_MSB:`LDM_CFG_DROOP_LSB];
	assign fault_lock_out       = lock_q;

endmodule

// *** ldm_consts.vh ***
/*
 * Constants of the LED driver mode and fault controller: register offsets,
 * field positions, reset values and timing figures.
 * Assumes a 10 MHz system clock; every cycle count is derived from it.
 */
`ifndef LDM_CONSTS_VH
`define LDM_CONSTS_VH

`define LDM_REG_ENABLE          8'h01
`define LDM_REG_CONFIG          8'h02
`define LDM_REG_FLASH           8'h03
`define LDM_REG_TORCH           8'h04
`define LDM_REG_FLAGS           8'h05
`define LDM_REG_IDENT           8'h06

`define LDM_RST_ENABLE          8'h20
`define LDM_RST_CONFIG          8'h15
`define LDM_RST_FLASH           8'h00
`define LDM_RST_TORCH           8'h00
`define LDM_RST_FLAGS           8'h00

`define LDM_MODE_STANDBY        2'h0
`define LDM_MODE_INFRARED       2'h1
`define LDM_MODE_TORCH          2'h2
`define LDM_MODE_FLASH          2'h3

`define LDM_EN_TRIG_ENABLE      2
`define LDM_EN_TRIG_TYPE        3
`define LDM_EN_DROOP_ENABLE     4
`define LDM_CFG_TORCH_RAMP      0
`define LDM_CFG_TIMEOUT_LSB     1
`define LDM_CFG_TIMEOUT_MSB     4
`define LDM_CFG_DROOP_LSB       5
`define LDM_CFG_DROOP_MSB       7
`define LDM_FLG_DROOP           6
`define LDM_FLG_SHORT           5
`define LDM_FLG_THERMAL         2
`define LDM_FLG_UNDERVOLT       1
`define LDM_ID_SOFT_RESET       7

`define LDM_I2C_ADDR            7'h64

`define LDM_CLK_MHZ             10
`define LDM_MS_US               1000
`define LDM_SHORT_DEGLITCH_US   256
`define LDM_TORCH_RAMP_US       1000
`define LDM_RAMP_LEVELS         128
`define LDM_FLASH_STEP_NS       800
`define LDM_SHORT_DEGLITCH_CYC  12'hA00
`define LDM_TORCH_STEP_CYC      8'h4E
`define LDM_FLASH_STEP_CYC      8'h08

`define LDM_TIMEOUT_FINE_CODES  4'hA
`define LDM_TIMEOUT_FINE_MS     11'h028
`define LDM_TIMEOUT_COARSE_MS   11'h258
`define LDM_TIMEOUT_COARSE_STEP 11'h0C8

`endif

// *** ldm_mode_fault_ctrl_assertions.sv ***
/* Concurrent checks on the ports of the LED mode and fault controller.
   Assumes one clock domain and clk_en_in held high by the bench. */
`timescale 1ns/100ps
module ldm_checker (
	// Clock and reset.
	input wire       sys_clk_in,
	input wire       rst_b_in,
	// Indications.
	input wire       trigger_in,
	input wire       supply_droop_monitor_in,
	input wire       thermal_shutdown_in,
	input wire       undervoltage_lockout_in,
	// Drive outputs.
	input wire [7:0] current_code_out,
	input wire [1:0] drive_mode_field_out,
	input wire       fault_lock_out
);
	wire [7:0] code = current_code_out;
	wire [1:0] mode = drive_mode_field_out;
	default clocking dc @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_b_in);
	a_standby_code_off: assert property ((mode == 2'h0)[*2] |-> code == 8'h00)
		else $error("code not off in standby");
	a_flash_step_one: assert property (mode == 2'h3 && $past(mode) == 2'h3 && code > $past(code) |-> code == $past(code) + 8'h01)
		else $error("flash ramp skipped a level");
	a_target_seven_bit: assert property (mode[1] && $past(mode) == mode |-> code[7] == 1'b0)
		else $error("flash or torch code above seven bits");
	a_ir_no_ramp: assert property (mode == 2'h1 && $past(mode) == 2'h1 && code != $past(code) |-> code == 8'h00 || $past(code) == 8'h00)
		else $error("infrared code ramped");
	a_ir_trig_off: assert property ((mode == 2'h1 && !trigger_in)[*5] |-> code == 8'h00)
		else $error("infrared drive without trigger");
	a_droop_halts: assert property ((mode == 2'h3 && supply_droop_monitor_in)[*6] |-> $stable(code))
		else $error("flash ramp advanced during droop");
	a_lock_holds_stby: assert property (fault_lock_out[*3] |-> mode == 2'h0)
		else $error("mode left standby while locked");
	a_fault_to_stby: assert property ($rose(fault_lock_out) |-> ##[0:1] mode == 2'h0)
		else $error("fault did not force standby");
	a_undervoltage_lockout_lockout: assert property (undervoltage_lockout_in[*5] |-> ##[0:2] fault_lock_out)
		else $error("undervoltage did not lock");
	a_tsd_lockout: assert property (thermal_shutdown_in[*5] |-> ##[0:2] fault_lock_out)
		else $error("thermal shutdown did not lock");
endmodule
bind ldm_mode_fault_ctrl ldm_checker i_chk (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .trigger_in(trigger_in),
	.supply_droop_monitor_in(supply_droop_monitor_in), .thermal_shutdown_in(thermal_shutdown_in),
	.undervoltage_lockout_in(undervoltage_lockout_in), .current_code_out(current_code_out),
	.drive_mode_field_out(drive_mode_field_out), .fault_lock_out(fault_lock_out));

// *** ldm_host_model.sv ***
/* Two-wire host model that reaches the controller's registers.
   Assumes a pull-up outside resolves the data wire from all pull-downs. */
`timescale 1ns/100ps
module ldm_host_model (
	// Clock and wire.
	input  wire  clk_in,
	input  wire  sda_in,
	output logic scl_out,
	output logic sda_low_out
);
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	task automatic q(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// Phases of 6 clocks give a 2.4 us bit, slower than the slave's synchronised edge detection needs.
	task automatic bits(input [8:0] d, output [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			sda_low_out = !d[i];
			q(6);
			scl_out = 1'b1;
			q(6);
			r[i] = sda_in;
			q(6);
			scl_out = 1'b0;
			q(6);
		end
		sda_low_out = 1'b0;
	endtask
	task automatic start;
		sda_low_out = 1'b0;
		q(6);
		scl_out = 1'b1;
		q(6);
		sda_low_out = 1'b1;
		q(6);
		scl_out = 1'b0;
		q(6);
	endtask
	task automatic stop;
		sda_low_out = 1'b1;
		q(6);
		scl_out = 1'b1;
		q(6);
		sda_low_out = 1'b0;
		q(6);
	endtask
	task automatic wr(input [7:0] a, input [7:0] v, output logic nak);
		logic [8:0] r0, r1, r2;
		start();
		bits({8'hC8, 1'b1}, r0);
		bits({a, 1'b1}, r1);
		bits({v, 1'b1}, r2);
		stop();
		nak = r0[0] | r1[0] | r2[0];
	endtask
	task automatic rd(input [7:0] a, output logic [7:0] v, output logic nak);
		logic [8:0] r0, r1, r2, r3;
		start();
		bits({8'hC8, 1'b1}, r0);
		bits({a, 1'b1}, r1);
		start();
		bits({8'hC9, 1'b1}, r2);
		bits(9'h1FF, r3);
		stop();
		v = r3[8:1];
		nak = r0[0] | r1[0] | r2[0];
	endtask
endmodule

// *** tb_top.sv ***
/* Self-checking bench of the LED mode and fault controller.
   Assumes the host model on the serial pins and a pull-up on data. */
`timescale 1ns/100ps
module tb_top;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        trig = 1'b0;
	logic [4:0]  ind = 5'h00;
	logic        scl;
	logic        hlow;
	logic        oe;
	logic        nak;
	logic [7:0]  d;
	logic [7:0]  c0;
	logic [7:0]  code;
	logic [1:0]  mode;
	logic [2:0]  thr;
	logic        lock;
	int          n_errors = 0;
	int          checks = 0;
	logic [31:0] rows [7] = '{32'h01203434, 32'h0215E0E0, 32'h03009F9F, 32'h04000505,
		32'h0500FF00, 32'h063C113C, 32'h07005A00};
	wire         sda = !(hlow | oe);
	always #50 clk = !clk;
	// A millisecond of 10 cycles keeps every time-out short.
	ldm_mode_fault_ctrl #(.MS_CYCLES(10), .ID_VALUE(8'h3C)) i_dut (.sys_clk_in(clk), .rst_b_in(rst_b),
		.clk_en_in(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_out(oe), .trigger_in(trig),
		.supply_droop_monitor_in(ind[0]), .led_short_in(ind[1]), .thermal_scaleback_in(ind[2]),
		.thermal_shutdown_in(ind[3]), .undervoltage_lockout_in(ind[4]), .current_code_out(code),
		.drive_mode_field_out(mode), .droop_threshold_out(thr), .fault_lock_out(lock));
	ldm_host_model i_host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(hlow));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string s, input [7:0] e, input [7:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic w(input [7:0] a, input [7:0] v);
		i_host.wr(a, v, nak);
		chk("ack", 8'h00, {7'h0, nak});
	endtask
	task automatic r(input [7:0] a, input [7:0] e);
		i_host.rd(a, d, nak);
		chk("ack", 8'h00, {7'h0, nak});
		chk("read", e, d);
	endtask
	task automatic complete_run;
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		cyc(12);
		chk("rst code", 8'h00, code);
		chk("rst pins", 8'h00, {4'h0, oe, lock, mode});
		rst_b = 1'b1;
		cyc(4);
		foreach (rows[i]) begin
			r(rows[i][31:24], rows[i][23:16]);
			w(rows[i][31:24], rows[i][15:8]);
			r(rows[i][31:24], rows[i][7:0]);
		end
		chk("thr", 8'h07, {5'h0, thr});
		w(8'h01, 8'h37);
		cyc(300);
		chk("flash", 8'h1F, code);
		chk("mode", 8'h03, {6'h0, mode});
		cyc(120);
		chk("tmo", 8'h00, {6'h0, mode});
		r(8'h01, 8'h34);
		w(8'h01, 8'h37);
		ind[0] = 1'b1;
		cyc(50);
		c0 = code;
		cyc(100);
		chk("droop", c0, code);
		chk("droop low", 8'h01, {7'h0, code < 8'h1F});
		ind[0] = 1'b0;
		r(8'h05, 8'h40);
		w(8'h01, 8'h35);
		chk("ir off", 8'h00, code);
		trig = 1'b1;
		cyc(5);
		chk("ir on", 8'h9F, code);
		trig = 1'b0;
		cyc(5);
		chk("ir off", 8'h00, code);
		trig = 1'b1;
		cyc(450);
		chk("ir tmo", 8'h00, {6'h0, mode});
		trig = 1'b0;
		w(8'h01, 8'h36);
		chk("torch", 8'h05, code);
		w(8'h02, 8'hE1);
		w(8'h01, 8'h34);
		w(8'h01, 8'h36);
		chk("ramp", 8'h01, {7'h0, code < 8'h05});
		cyc(400);
		chk("torch", 8'h05, code);
		ind[4] = 1'b1;
		cyc(10);
		chk("lock", 8'h01, {7'h0, lock});
		chk("stby", 8'h00, {6'h0, mode});
		ind[4] = 1'b0;
		w(8'h01, 8'h36);
		chk("held", 8'h00, {6'h0, mode});
		r(8'h05, 8'h02);
		cyc(5);
		chk("unlock", 8'h00, {7'h0, lock});
		ind[3] = 1'b1;
		cyc(10);
		r(8'h05, 8'h04);
		cyc(5);
		chk("relock", 8'h01, {7'h0, lock});
		ind[3] = 1'b0;
		r(8'h05, 8'h04);
		r(8'h05, 8'h00);
		w(8'h01, 8'h37);
		cyc(250);
		ind[2] = 1'b1;
		cyc(10);
		chk("tsb", 8'h05, code);
		chk("tsb mode", 8'h03, {6'h0, mode});
		ind[2] = 1'b0;
		r(8'h05, 8'h04);
		w(8'h01, 8'h36);
		ind[1] = 1'b1;
		cyc(2400);
		chk("glitch", 8'h00, {7'h0, lock});
		cyc(300);
		chk("short", 8'h01, {7'h0, lock});
		ind[1] = 1'b0;
		w(8'h06, 8'h80);
		r(8'h05, 8'h00);
		r(8'h01, 8'h20);
		complete_run();
	end
	initial begin
		cyc(90000);
		n_errors++;
		complete_run();
	end
endmodule
